// [rtl/twc_timer.sv]
// Purpose: Programmable timer/counter with prescaler and output pin
// Assumes: Single clock, synchronous reset, APB register access
// Notes: Watchdog reset generation and reload sequence are not here
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module twc_timer
	import twc_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic WATCHDOG_EN,
	input wire logic TIMER_INPUT_PIN,
	output logic TIMER_OUTPUT_PIN,
	output logic END_COUNT_EVT
);
	twc_state_s s_r;
	twc_state_s s_nxt;
	logic wr;
	logic rd;
	logic hit;
	logic fall;
	logic run;
	logic tick;
	logic step;
	logic eoc;
	logic restart;
	logic start;
	logic [1:0] md;

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == TWC_OFF_CNT_HI) || (a == TWC_OFF_CNT_LO) || (a == TWC_OFF_PRESC)
			|| (a == TWC_OFF_CTRL) || (a == TWC_OFF_STAT);
	endfunction

	// A frozen block cannot take a write, so it holds the access off
	assign PREADY = CLK_EN;
	assign wr = PSEL && PENABLE && PWRITE && CLK_EN;
	// Read data captured from setup on, so it stands at the ready edge
	assign rd = PSEL && !PWRITE && CLK_EN;
	assign hit = addr_ok(PADDR);
	assign PSLVERR = PSEL && PENABLE && !hit;
	assign PRDATA = s_r.prdata;
	assign TIMER_OUTPUT_PIN = s_r.out;
	assign END_COUNT_EVT = s_r.evt;
	assign md = {s_r.ctrl[TWC_B_MD1], s_r.ctrl[TWC_B_MD2]};

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.evt = 1'b0;
		s_nxt.pin_s1 = TIMER_INPUT_PIN;
		s_nxt.pin_s2 = s_r.pin_s1;
		s_nxt.pin_d = s_r.pin_s2;
		fall = s_r.pin_d && !s_r.pin_s2;
		run = s_r.ctrl[TWC_B_RUN] || WATCHDOG_EN;
		start = 1'b0;
		restart = 1'b0;
		// Internal time base is clock/4
		s_nxt.div4 = s_r.div4 + 2'h1;
		tick = (s_r.div4 == TWC_DIV4_LAST);
		if (!run)
		begin
			step = 1'b0;
			s_nxt.armed = 1'b0;
		end
		else if (s_r.ctrl[TWC_B_EXTERNAL_INPUT_ENABLE] && !WATCHDOG_EN)
		begin
			unique case (md)
				TWC_IN_EVENT: step = fall;
				TWC_IN_GATED: step = tick && s_r.pin_s2;
				TWC_IN_TRIG:
				begin
					// Armed by first falling edge after run is set
					if (fall)
						s_nxt.armed = 1'b1;
					step = tick && s_r.armed;
				end
				TWC_IN_RETRIG:
				begin
					step = tick && !fall;
					restart = fall;
				end
			endcase
		end
		else
			step = tick;
		// Prescaler divides by presc_k + 1
		tick = 1'b0;
		eoc = 1'b0;
		if (restart)
		begin
			s_nxt.cnt = s_r.konst;
			s_nxt.presc = s_r.presc_k;
			s_nxt.konst_new = 1'b0;
		end
		else if (step)
		begin
			if (s_r.presc == TWC_PRE_ZERO)
			begin
				s_nxt.presc = s_r.presc_k;
				if (s_r.cnt == TWC_CNT_ZERO)
					eoc = 1'b1;
				else
					s_nxt.cnt = s_r.cnt - 16'h0001;
			end
			else
				s_nxt.presc = s_r.presc - 8'h01;
		end
		if (eoc)
		begin
			s_nxt.evt = 1'b1;
			s_nxt.cnt = s_r.konst;
			s_nxt.konst_new = 1'b0;
			if (s_r.ctrl[TWC_B_SINGLE] && !WATCHDOG_EN)
				s_nxt.ctrl[TWC_B_RUN] = 1'b0;
			if (s_r.ctrl[TWC_B_OSTYLE])
				s_nxt.out = s_r.ctrl[TWC_B_SWLVL];
			else
				s_nxt.out = !s_r.out;
		end
		if (!s_r.ctrl[TWC_B_OEN])
			s_nxt.out = 1'b1;
		// Register writes
		if (wr && PADDR == TWC_OFF_CNT_HI)
		begin
			s_nxt.konst[15:8] = PWDATA[7:0];
			s_nxt.konst_new = 1'b1;
		end
		if (wr && PADDR == TWC_OFF_CNT_LO)
		begin
			s_nxt.konst[7:0] = PWDATA[7:0];
			s_nxt.konst_new = 1'b1;
		end
		if (wr && PADDR == TWC_OFF_PRESC)
		begin
			s_nxt.presc_k = PWDATA[7:0];
			s_nxt.presc = PWDATA[7:0];
		end
		if (wr && PADDR == TWC_OFF_CTRL)
		begin
			// Run and mode bits land in the same write
			s_nxt.ctrl = PWDATA[7:0];
			start = PWDATA[TWC_B_RUN] && !s_r.ctrl[TWC_B_RUN];
			if (eoc && s_r.ctrl[TWC_B_SINGLE] && !PWDATA[TWC_B_RUN])
				s_nxt.ctrl[TWC_B_RUN] = 1'b0;
		end
		// A stopped counter picks up a new constant when started
		if (start && s_r.konst_new && !WATCHDOG_EN)
		begin
			s_nxt.cnt = s_r.konst;
			s_nxt.konst_new = 1'b0;
		end
		if (rd)
		begin
			s_nxt.prdata = 32'h00000000;
			unique case (PADDR)
				TWC_OFF_CNT_HI: s_nxt.prdata[7:0] = s_r.cnt[15:8];
				TWC_OFF_CNT_LO: s_nxt.prdata[7:0] = s_r.cnt[7:0];
				TWC_OFF_PRESC: s_nxt.prdata[7:0] = s_r.presc_k;
				TWC_OFF_CTRL: s_nxt.prdata[7:0] = s_r.ctrl;
				TWC_OFF_STAT:
				begin
					s_nxt.prdata[TWC_S_EVT] = s_r.konst_new;
					s_nxt.prdata[TWC_S_WDG] = WATCHDOG_EN;
					s_nxt.prdata[TWC_S_OUT] = s_r.out;
				end
				default: s_nxt.prdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (SYS_RST)
		begin
			s_r <= '0;
			s_r.cnt <= {TWC_RST_HI, TWC_RST_LO};
			s_r.konst <= {TWC_RST_HI, TWC_RST_LO};
			s_r.presc <= TWC_RST_PRESC;
			s_r.presc_k <= TWC_RST_PRESC;
			s_r.ctrl <= TWC_RST_CTRL;
			s_r.out <= 1'b1;
			s_r.pin_s1 <= 1'b1;
			s_r.pin_s2 <= 1'b1;
			s_r.pin_d <= 1'b1;
		end
		else if (CLK_EN)
			s_r <= s_nxt;
	end
endmodule

// [rtl/twc_pkg.sv]
// Purpose: Constants and types for the timer/watchdog counter block
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes: Register map is word aligned from offset 0x00
package twc_pkg;
	localparam logic [7:0] TWC_OFF_CNT_HI = 8'h00;
	localparam logic [7:0] TWC_OFF_CNT_LO = 8'h04;
	localparam logic [7:0] TWC_OFF_PRESC = 8'h08;
	localparam logic [7:0] TWC_OFF_CTRL = 8'h0c;
	localparam logic [7:0] TWC_OFF_STAT = 8'h10;
	localparam logic [7:0] TWC_RST_HI = 8'hff;
	localparam logic [7:0] TWC_RST_LO = 8'hff;
	localparam logic [7:0] TWC_RST_PRESC = 8'hff;
	localparam logic [7:0] TWC_RST_CTRL = 8'h12;
	// Control register bit positions
	localparam int TWC_B_RUN = 7;
	localparam int TWC_B_SINGLE = 6;
	localparam int TWC_B_MD1 = 5;
	localparam int TWC_B_MD2 = 4;
	localparam int TWC_B_EXTERNAL_INPUT_ENABLE = 3;
	localparam int TWC_B_OSTYLE = 2;
	localparam int TWC_B_SWLVL = 1;
	localparam int TWC_B_OEN = 0;
	// Status register bit positions
	localparam int TWC_S_EVT = 0;
	localparam int TWC_S_WDG = 1;
	localparam int TWC_S_OUT = 2;
	localparam logic [1:0] TWC_DIV4_LAST = 2'h3;
	localparam logic [15:0] TWC_CNT_ZERO = 16'h0000;
	localparam logic [7:0] TWC_PRE_ZERO = 8'h00;
	typedef enum logic [1:0]
	{
		TWC_IN_EVENT = 2'b00,
		TWC_IN_GATED = 2'b01,
		TWC_IN_TRIG = 2'b10,
		TWC_IN_RETRIG = 2'b11
	} twc_inmode_e;
	typedef struct packed
	{
		logic [15:0] cnt;
		logic [15:0] konst;
		logic konst_new;
		logic [7:0] presc;
		logic [7:0] presc_k;
		logic [7:0] ctrl;
		logic [1:0] div4;
		logic armed;
		logic out;
		logic evt;
		logic pin_s1;
		logic pin_s2;
		logic pin_d;
		logic [31:0] prdata;
	} twc_state_s;
endpackage

// [bench/twc_src_model.sv]
// Purpose: Source for the timer input pin
// Assumes: Toggles every HALF clocks while go is high
// Notes: Rests high when idle
`timescale 1ns/1ns
module twc_src_model #(parameter int HALF = 5)
(
	input wire logic clk,
	input wire logic go,
	output logic pin = 1'b1
);
	int t = 0;
	always @(posedge clk)
	begin
		t <= go ? (t + 1) % HALF : 0;
		pin <= go ? pin ^ (t == HALF - 1) : 1'b1;
	end
endmodule

// [bench/twc_timer_checker.sv]
// Purpose: Port assertions for the timer
// Assumes: One clock domain
// Notes: Bound below
`timescale 1ns/1ns
module twc_timer_checker
	import twc_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic TIMER_OUTPUT_PIN,
	input wire logic END_COUNT_EVT
);
	wire acc = PSEL && PENABLE && CLK_EN;
	wire hit = PADDR <= TWC_OFF_STAT && PADDR[1:0] == 2'h0;
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (SYS_RST);
	chk_ready_high: assert property (PSEL && PENABLE && CLK_EN |-> PREADY)
		else $error("pready low");
	chk_err_bad: assert property (acc && !hit |-> PSLVERR)
		else $error("no slverr");
	chk_err_good: assert property (acc && hit |-> !PSLVERR)
		else $error("false slverr");
	chk_rd_zero: assert property (acc && !PWRITE && !hit |-> PRDATA == 32'h0)
		else $error("unmapped data");
	chk_rd_hold: assert property (!(PSEL && !PWRITE && CLK_EN) |=> $stable(PRDATA))
		else $error("rdata moved");
	chk_reset_vals: assert property (disable iff (1'b0)
		SYS_RST && CLK_EN |=> TIMER_OUTPUT_PIN && !END_COUNT_EVT) else $error("reset values");
	chk_evt_once: assert property (END_COUNT_EVT && CLK_EN |=> !END_COUNT_EVT)
		else $error("long event");
	chk_out_cause: assert property ($changed(TIMER_OUTPUT_PIN)
		&& !$past(acc && PWRITE) |-> $past(END_COUNT_EVT) or ##[0:1] END_COUNT_EVT)
		else $error("stray output edge");
	cov_evt: cover property (END_COUNT_EVT);
	cov_bad: cover property (acc && !hit);
	cov_wr: cover property (acc && PWRITE && PADDR == TWC_OFF_CTRL);
endmodule
bind twc_timer twc_timer_checker u_twc_timer_checker (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
	.CLK_EN(CLK_EN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN), .END_COUNT_EVT(END_COUNT_EVT));

// [bench/timer_watchdog_counter_tb.sv]
// Purpose: Self-checking bench for the timer
// Assumes: Read data is taken at the edge that sees pready high
// Notes: Periods are predicted in clock cycles
`timescale 1ns/1ns
module timer_watchdog_counter_tb;
	import twc_pkg::*;
	logic SYS_CLK = 0, SYS_RST = 1, CLK_EN = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic WATCHDOG_EN = 0, go = 0, o, PREADY, PSLVERR, TIMER_INPUT_PIN, TIMER_OUTPUT_PIN;
	logic END_COUNT_EVT;
	logic [7:0] PADDR = 0;
	logic [31:0] PWDATA = 0, PRDATA, rd;
	logic [7:0] ra[5] = '{TWC_OFF_CNT_HI, TWC_OFF_CNT_LO, TWC_OFF_PRESC, TWC_OFF_CTRL, 8'h14};
	logic [7:0] rv[5] = '{TWC_RST_HI, TWC_RST_LO, TWC_RST_PRESC, TWC_RST_CTRL, 8'h00};
	int mismatches = 0, n_tests = 0, cyc = 0, seed = 52910, n, p, k;
	always #50 SYS_CLK = ~SYS_CLK;
	twc_timer u_twc_timer (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .WATCHDOG_EN(WATCHDOG_EN),
		.TIMER_INPUT_PIN(TIMER_INPUT_PIN), .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN),
		.END_COUNT_EVT(END_COUNT_EVT));
	twc_src_model u_twc_src_model (.clk(SYS_CLK), .go(go), .pin(TIMER_INPUT_PIN));
	task automatic summarize();
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		do
			@(posedge SYS_CLK);
		while (PREADY !== 1'b1);
		rd = PRDATA;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	// Returns cycles to the next event, then lets two edges pass
	task automatic wev(output int c);
		c = 0;
		do
		begin
			@(posedge SYS_CLK);
			c++;
		end
		while (END_COUNT_EVT !== 1'b1);
		repeat (2) @(posedge SYS_CLK);
	endtask
	always @(posedge SYS_CLK)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			mismatches++;
			summarize();
		end
	end
	initial
	begin
		repeat (12) @(posedge SYS_CLK);
		SYS_RST <= 1'b0;
		foreach (ra[i])
		begin
			apb(1'b0, ra[i], 32'h0);
			cmp(rd, {24'h0, rv[i]});
		end
		cmp(TIMER_OUTPUT_PIN, 1'b1);
		p = $random(seed) & 3;
		apb(1'b1, TWC_OFF_CNT_HI, 32'h0);
		apb(1'b1, TWC_OFF_CNT_LO, 32'h3);
		apb(1'b1, TWC_OFF_PRESC, p);
		apb(1'b1, TWC_OFF_CTRL, 32'h81);
		wev(n);
		o = TIMER_OUTPUT_PIN;
		wev(n);
		cmp(n + 2, 16 * (p + 1));
		cmp(TIMER_OUTPUT_PIN ^ o, 1'b1);
		apb(1'b1, TWC_OFF_CNT_LO, 32'h7);
		wev(n);
		wev(n);
		cmp(n + 2, 32 * (p + 1));
		apb(1'b1, TWC_OFF_CTRL, 32'hc1);
		wev(n);
		apb(1'b0, TWC_OFF_CTRL, 32'h0);
		cmp(rd, 32'h41);
		apb(1'b0, TWC_OFF_CNT_LO, 32'h0);
		cmp(rd, 32'h7);
		go <= 1'b1;
		apb(1'b1, TWC_OFF_CTRL, 32'h89);
		wev(n);
		wev(n);
		cmp(n + 2, 80 * (p + 1));
		for (int lv = 0; lv < 2; lv++)
		begin
			apb(1'b1, TWC_OFF_CTRL, 32'h8d | (lv << 1));
			wev(n);
			cmp(TIMER_OUTPUT_PIN, lv);
		end
		// Retrigger every 10 clocks keeps a constant of 7 from expiring
		apb(1'b1, TWC_OFF_CTRL, 32'hb9);
		repeat (20) @(posedge SYS_CLK);
		k = 0;
		repeat (300) @(posedge SYS_CLK) k += END_COUNT_EVT;
		cmp(k, 0);
		go <= 1'b0;
		apb(1'b1, TWC_OFF_CTRL, 32'h08);
		apb(1'b1, TWC_OFF_CNT_LO, 32'h7);
		apb(1'b1, TWC_OFF_CTRL, 32'ha9);
		repeat (100) @(posedge SYS_CLK);
		apb(1'b0, TWC_OFF_CNT_LO, 32'h0);
		cmp(rd, 32'h7);
		apb(1'b1, TWC_OFF_CTRL, 32'h99);
		wev(n);
		wev(n);
		cmp(n + 2, 32 * (p + 1));
		apb(1'b1, TWC_OFF_CTRL, 32'h08);
		@(posedge SYS_CLK);
		cmp(TIMER_OUTPUT_PIN, 1'b1);
		WATCHDOG_EN <= 1'b1;
		wev(n);
		wev(n);
		cmp(n + 2, 32 * (p + 1));
		summarize();
	end
endmodule
